/* File: rtl/sfsr_regs.svh */
// Function
// - After the status-read opcode, one status bit leaves on every following clock.
// - Byte one bit 7..0, then byte two bit 7..0, repeating while selected.
// - Each two-byte repetition carries a freshly sampled copy of live status.
// - Status reads are served at any time, even during program or erase.
// - Chip select release ends the read and floats the serial output.
// - Byte one: lock, 0, error, pin level, 0, protection, write latch, busy.
// - Write-status changes only the lock and protection bits of byte one.
// - Lock set with protect pin asserted freezes the protection bit.
// - Lock clears at power-up; while clear, protection stays writable.
// - Protect pin asserted: lock may only rise; clearing needs pin released.
// - Error flag follows each program/erase end, set when a byte failed.
// - An aborted program or erase leaves the error flag unchanged.
// - Pin level bit reads 0 while pin asserted, 1 while released.
// - Protection bit 1 blocks all program and erase on the array.
// - Write latch clear rejects program, erase, security program, write-status.
// - Write latch is 0 after power-up and after a reset operation.
// - Write latch clears on write-disable, write-op complete or abort, hold abort.
// - Short or unknown opcode aborts leave the write latch unchanged.
// - Busy bit is 1 during internal work; host polls until it falls.
// - Busy appears in bit 0 of both status bytes, same value.
// - Byte two: reset enable at bit 4, default 0; busy bit 0; rest 0.
// - Write-status is opcode plus one byte, applied at release, then latch clears.
//
// Purpose: Constants of the serial flash status register block
// Assumes: Included by bare name, definitions only
// Notes:   Opcodes are one byte each
`ifndef SFSR_REGS_SVH
`define SFSR_REGS_SVH

// Opcodes
`define SFSR_OP_READ_STATUS   8'h05
`define SFSR_OP_WRITE_STATUS  8'h01
`define SFSR_OP_WRITE_STATUS2 8'h31
`define SFSR_OP_WRITE_ENABLE  8'h06
`define SFSR_OP_WRITE_DISABLE 8'h04

// Byte one field positions
`define SFSR_B1_LOCK  7
`define SFSR_B1_ERROR 5
`define SFSR_B1_PIN   4
`define SFSR_B1_PROT  2
`define SFSR_B1_WEL   1
`define SFSR_B1_BUSY  0

// Byte two field positions
`define SFSR_B2_RESET_COMMAND_ENABLE  4
`define SFSR_B2_BUSY  0

// Reset values
`define SFSR_LOCK_RST  1'h0
`define SFSR_PROT_RST  1'h0
`define SFSR_WEL_RST   1'h0
`define SFSR_ERROR_RST 1'h0
`define SFSR_RESET_COMMAND_ENABLE_RST  1'h0

// Frame length counts, in link clocks and bytes
`define SFSR_BITS_PER_BYTE 3'h7
`define SFSR_DATA_BYTES    2'h2

`endif

/* File: rtl/sfsr_pkg.sv */
// Purpose: Types and opcode decoding of the status register block
// Assumes: Header of constants available on the include path
// Notes:   Decoder shared by link side and core side
`include "sfsr_regs.svh"

package sfsr_pkg;

  // Command classes seen at the link
  typedef enum logic [2:0] {
    SFSR_CMD_OTHER,
    SFSR_CMD_READ,
    SFSR_CMD_WRSR,
    SFSR_CMD_WRSR2,
    SFSR_CMD_WREN,
    SFSR_CMD_WRDI
  } sfsr_cmd_e;

  typedef logic [7:0] sfsr_byte_t;

  // Opcode to command class
  function automatic sfsr_cmd_e sfsr_decode(input sfsr_byte_t op);
    case (op)
      `SFSR_OP_READ_STATUS:   return SFSR_CMD_READ;
      `SFSR_OP_WRITE_STATUS:  return SFSR_CMD_WRSR;
      `SFSR_OP_WRITE_STATUS2: return SFSR_CMD_WRSR2;
      `SFSR_OP_WRITE_ENABLE:  return SFSR_CMD_WREN;
      `SFSR_OP_WRITE_DISABLE: return SFSR_CMD_WRDI;
      default:                return SFSR_CMD_OTHER;
    endcase
  endfunction : sfsr_decode

endpackage : sfsr_pkg

/* File: rtl/sfsr_status_reg.sv */
// Purpose: Status register bank of a serial flash, with its serial read-out
// Assumes: Link in mode 0 (sample rising, shift falling); link clock still between frames
// Notes:   Program/erase engines sit outside and talk through busy, latch, error
`timescale 1ns/1ns
`include "sfsr_regs.svh"

module sfsr_status_reg #(
  parameter int SYNC_STAGES = 2
) (
  // Core clock and reset
  input  wire logic       ref_clk,
  input  wire logic       reset,
  // Serial link, clocked by the host
  input  wire logic       spiClk,
  input  wire logic       csN,
  input  wire logic       serialIn,
  output logic            serialOut,
  output logic            serialOutEn,
  // Write protect pin, active low
  input  wire logic       wpN,
  // Program and erase engine side
  input  wire logic       engineBusy,
  input  wire logic       engineDone,
  input  wire logic       engineFail,
  input  wire logic       engineAbort,
  input  wire logic       holdAbort,
  input  wire logic       resetOp,
  // Status towards the engines
  output logic            writeEnabled,
  output logic            arrayProtected,
  output logic            protectionLock,
  output logic            resetCmdEnabled,
  output logic            errorFlag,
  output logic [7:0]      statusByteOne
);

  // Refuse synchroniser depths that cannot settle metastability
  if (SYNC_STAGES < 2) begin : gBadSync
    $error("SYNC_STAGES must be at least 2");
  end

  // ---------------------------------------------------------------
  // Link domain: frame tracking on the rising serial clock
  // ---------------------------------------------------------------

  logic                 frameOpen_r;
  logic [2:0]           bitCnt_r;
  logic [1:0]           byteCnt_r;
  logic [7:0]           shift_r;
  logic [7:0]           cmd_r;
  logic [7:0]           data_r;
  logic [3:0]           statPos_r;
  logic [2:0]           bitBase;
  logic [1:0]           byteBase;
  logic [7:0]           shiftNxt;
  logic                 byteDone;

  // Frame open flag, cleared by the frame's own select release
  always_ff @(posedge spiClk or posedge csN) begin
    if (csN) begin
      frameOpen_r <= 1'h0;
    end else begin
      frameOpen_r <= 1'h1;
    end
  end

  // Counters restart on the first edge of a frame
  always_comb begin
    bitBase  = frameOpen_r ? bitCnt_r : 3'h0;
    byteBase = frameOpen_r ? byteCnt_r : 2'h0;
    shiftNxt = {shift_r[6:0], serialIn};
    byteDone = (bitBase == `SFSR_BITS_PER_BYTE);
  end

  // Bit and byte position within the frame; kept after release for the core
  always_ff @(posedge spiClk) begin
    bitCnt_r <= bitBase + 3'h1;
    shift_r  <= shiftNxt;
    if (byteDone && (byteBase != `SFSR_DATA_BYTES)) begin
      byteCnt_r <= byteBase + 2'h1;
    end else begin
      byteCnt_r <= byteBase;
    end
  end

  // Opcode and first data byte; later bytes ignored
  always_ff @(posedge spiClk) begin
    if (byteDone && (byteBase == 2'h0)) begin
      cmd_r <= shiftNxt;
    end
    if (byteDone && (byteBase == 2'h1)) begin
      data_r <= shiftNxt;
    end
  end

  // Position in the sixteen-bit status sequence, zero right after the opcode
  always_ff @(posedge spiClk) begin
    if (byteDone && (byteBase == 2'h0)) begin
      statPos_r <= 4'h0;
    end else begin
      statPos_r <= statPos_r + 4'h1;
    end
  end

  // ---------------------------------------------------------------
  // Status word carried into the link domain
  // ---------------------------------------------------------------

  logic [15:0]          statusWord_r;
  logic [15:0]          liveWord;

  // Per-bit level synchronisers; each bit is meaningful on its own
  // Trade-off: bits may settle one link clock apart, never torn within a bit
  for (genvar i = 0; i < 16; i++) begin : gStatSync
    logic [SYNC_STAGES-1:0] pipe_r;
    always_ff @(posedge spiClk) begin
      pipe_r <= {pipe_r[SYNC_STAGES-2:0], statusWord_r[i]};
    end
    assign liveWord[i] = pipe_r[SYNC_STAGES-1];
  end

  // ---------------------------------------------------------------
  // Link domain: serial output on the falling serial clock
  // ---------------------------------------------------------------

  logic [15:0]          snap_r;
  logic                 readMode;

  // Read mode once a whole status-read opcode is in
  always_comb begin
    readMode = frameOpen_r && (byteCnt_r != 2'h0)
               && (sfsr_pkg::sfsr_decode(cmd_r) == sfsr_pkg::SFSR_CMD_READ);
  end

  // Fresh snapshot at the start of every two-byte repetition
  always_ff @(negedge spiClk) begin
    if (readMode && (statPos_r == 4'h0)) begin
      snap_r <= liveWord;
    end
  end

  // Output bit and enable; release floats the pin at once
  always_ff @(negedge spiClk or posedge csN) begin
    if (csN) begin
      serialOut   <= 1'h0;
      serialOutEn <= 1'h0;
    end else if (readMode) begin
      serialOutEn <= 1'h1;
      if (statPos_r == 4'h0) begin
        serialOut <= liveWord[15];
      end else begin
        serialOut <= snap_r[~statPos_r];
      end
    end else begin
      serialOut   <= 1'h0;
      serialOutEn <= 1'h0;
    end
  end

  // ---------------------------------------------------------------
  // Core domain: pin synchronisers and frame end detection
  // ---------------------------------------------------------------

  logic [SYNC_STAGES-1:0] csPipe_r;
  logic [SYNC_STAGES-1:0] wpPipe_r;
  logic                 csPrev_r;
  logic                 csSync;
  logic                 wpLevel;
  logic                 frameEnd;

  // Select and protect pin brought onto the core clock; idle high
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      csPipe_r <= '1;
      wpPipe_r <= '1;
      csPrev_r <= 1'h1;
    end else begin
      csPipe_r <= {csPipe_r[SYNC_STAGES-2:0], csN};
      wpPipe_r <= {wpPipe_r[SYNC_STAGES-2:0], wpN};
      csPrev_r <= csSync;
    end
  end

  assign csSync   = csPipe_r[SYNC_STAGES-1];
  assign wpLevel  = wpPipe_r[SYNC_STAGES-1];
  assign frameEnd = csSync & ~csPrev_r;

  // ---------------------------------------------------------------
  // Core domain: command decode at frame end
  // ---------------------------------------------------------------

  // Frame registers are still because the link clock stops with the frame
  sfsr_pkg::sfsr_cmd_e  kind;
  logic                 opcodeIn;
  logic                 aligned;
  logic                 dataIn;
  logic                 wpAsserted;
  logic                 wrsrSeen;
  logic                 wrsr2Seen;
  logic                 wrsrApply;
  logic                 wrsr2Apply;
  logic                 lockRefused;
  logic                 welSet;
  logic                 welClear;

  always_comb begin
    kind       = sfsr_pkg::sfsr_decode(cmd_r);
    opcodeIn   = (byteCnt_r != 2'h0);
    aligned    = (bitCnt_r == 3'h0);
    dataIn     = (byteCnt_r == `SFSR_DATA_BYTES) && aligned;
    wpAsserted = ~wpLevel;
    // Only full opcodes count; a short or unknown one is ignored
    wrsrSeen   = frameEnd && opcodeIn && (kind == sfsr_pkg::SFSR_CMD_WRSR);
    wrsr2Seen  = frameEnd && opcodeIn && (kind == sfsr_pkg::SFSR_CMD_WRSR2);
    // Writes need the latch and a whole data byte, and are dropped while busy
    wrsrApply  = wrsrSeen && writeEnabled && dataIn && !engineBusy;
    wrsr2Apply = wrsr2Seen && writeEnabled && dataIn && !engineBusy;
    // Clearing the lock while the pin is asserted voids the whole write
    lockRefused = wpAsserted && protectionLock && !data_r[`SFSR_B1_LOCK];
  end

  // Latch set and clear causes
  always_comb begin
    welSet   = frameEnd && opcodeIn && aligned
               && (kind == sfsr_pkg::SFSR_CMD_WREN);
    welClear = resetOp
               || holdAbort
               || engineAbort
               || engineDone
               || (frameEnd && opcodeIn && (kind == sfsr_pkg::SFSR_CMD_WRDI))
               || (writeEnabled && (wrsrSeen || wrsr2Seen));
  end

  // ---------------------------------------------------------------
  // Core domain: status bits
  // ---------------------------------------------------------------

  // Write enable latch; a set in the same cycle as a clear wins
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      writeEnabled <= `SFSR_WEL_RST;
    end else if (welSet) begin
      writeEnabled <= 1'h1;
    end else if (welClear) begin
      writeEnabled <= 1'h0;
    end
  end

  // Lock bit; cleared at power-up, may only rise while pin asserted
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      protectionLock <= `SFSR_LOCK_RST;
    end else if (wrsrApply && !lockRefused) begin
      protectionLock <= data_r[`SFSR_B1_LOCK];
    end
  end

  // Protection bit; frozen by lock together with the asserted pin
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      arrayProtected <= `SFSR_PROT_RST;
    end else if (wrsrApply && !lockRefused
                 && !(protectionLock && wpAsserted)) begin
      arrayProtected <= data_r[`SFSR_B1_PROT];
    end
  end

  // Reset command enable in byte two
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      resetCmdEnabled <= `SFSR_RESET_COMMAND_ENABLE_RST;
    end else if (wrsr2Apply) begin
      resetCmdEnabled <= data_r[`SFSR_B2_RESET_COMMAND_ENABLE];
    end
  end

  // Error flag follows each completed operation; aborts leave it alone
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      errorFlag <= `SFSR_ERROR_RST;
    end else if (engineDone) begin
      errorFlag <= engineFail;
    end
  end

  // Assembled word; busy shows in both bytes, pin level is the synced, uninverted level
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      statusWord_r <= 16'h0000;
    end else begin
      statusWord_r <= 16'h0000;
      statusWord_r[8 + `SFSR_B1_LOCK]  <= protectionLock;
      statusWord_r[8 + `SFSR_B1_ERROR] <= errorFlag;
      statusWord_r[8 + `SFSR_B1_PIN]   <= wpLevel;
      statusWord_r[8 + `SFSR_B1_PROT]  <= arrayProtected;
      statusWord_r[8 + `SFSR_B1_WEL]   <= writeEnabled;
      statusWord_r[8 + `SFSR_B1_BUSY]  <= engineBusy;
      statusWord_r[`SFSR_B2_RESET_COMMAND_ENABLE]      <= resetCmdEnabled;
      statusWord_r[`SFSR_B2_BUSY]      <= engineBusy;
    end
  end

  // Byte one for the core side, straight from the assembled word
  assign statusByteOne = statusWord_r[15:8];

endmodule : sfsr_status_reg

/* File: tb/sfsr_sva.sv */
// Purpose: Port checks of the status register bank
// Assumes: Bound to sfsr_status_reg, core clock only
// Notes:   Pin level is synced, so the pin level check allows a few edges
`timescale 1ns/1ns
module sfsr_sva (
  // Clock, reset, pins
  input wire logic       ref_clk,
  input wire logic       reset,
  input wire logic       csN,
  input wire logic       wpN,
  input wire logic       serialOutEn,
  // Engine side
  input wire logic       engineBusy,
  input wire logic       engineDone,
  input wire logic       engineFail,
  input wire logic       engineAbort,
  input wire logic       holdAbort,
  input wire logic       resetOp,
  // Status
  input wire logic       writeEnabled,
  input wire logic       arrayProtected,
  input wire logic       protectionLock,
  input wire logic       errorFlag,
  input wire logic [7:0] statusByteOne
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  // Engine pulses and the flags they move
  AST_DONE_ERR: assert property (engineDone |=> errorFlag == $past(engineFail))
    else $error("error flag not taken from fail");
  AST_NODONE_ERR: assert property (!engineDone |=> $stable(errorFlag))
    else $error("error flag moved without done");
  AST_CLR_WEL: assert property ((engineDone || engineAbort || holdAbort || resetOp)
    |=> !writeEnabled) else $error("latch not cleared");
  // Byte one layout, one edge behind the bits
  AST_B1_MAP: assert property (statusByteOne == {$past(protectionLock), 1'h0,
    $past(errorFlag), statusByteOne[4], 1'h0, $past(arrayProtected), $past(writeEnabled),
    $past(engineBusy)}) else $error("byte one layout wrong");
  AST_PIN: assert property ($stable(wpN)[*5] |-> statusByteOne[4] == wpN)
    else $error("pin level bit wrong");
  // Writes land only at release, together with the latch clear
  AST_WR_REL: assert property ($changed({protectionLock, arrayProtected})
    |-> csN && $fell(writeEnabled)) else $error("write outside release");
  AST_FREEZE: assert property (!wpN && protectionLock |=> $stable(arrayProtected))
    else $error("protection changed while frozen");
  AST_LOCK_UP: assert property (!wpN |=> !$fell(protectionLock))
    else $error("lock cleared with pin asserted");
  AST_OE_CS: assert property (csN |-> !serialOutEn)
    else $error("output driven while deselected");
  // Main scenarios reached
  cover property (engineDone && engineFail);
  cover property (engineBusy && !csN);
  cover property ($fell(protectionLock));
endmodule : sfsr_sva

bind sfsr_status_reg sfsr_sva chk_u (.ref_clk, .reset, .csN, .wpN, .serialOutEn,
  .engineBusy, .engineDone, .engineFail, .engineAbort, .holdAbort, .resetOp,
  .writeEnabled, .arrayProtected, .protectionLock, .errorFlag, .statusByteOne);

/* File: tb/sfsr_spi_host.sv */
// Purpose: Host end of the serial link, one frame per call
// Assumes: Mode 0, link clock low and still between frames
// Notes:   Released data line shows the inverse of its last level
`timescale 1ns/1ns
module sfsr_spi_host (
  // Link towards the device
  output logic      spiClk,
  output logic      csN,
  output logic      serialIn,
  input  wire logic serialOut,
  input  wire logic serialOutEn
);
  // Idle link
  initial begin
    spiClk = 1'h0;
    csN = 1'h0;
    serialIn = 1'h0;
    // Real rise of select so the link flags start cleared, not unknown
    #1 csN = 1'h1;
  end
  // n clocks, tx sent from bit 71 down, rx keeps the last samples
  task automatic xfer(input logic [71:0] tx, input int n, output logic [71:0] rx);
    rx = '0;
    #5 csN = 1'h0;
    for (int j = 0; j < n; j++) begin
      serialIn = tx[71 - j];
      #16 spiClk = 1'h1;
      // Undriven output line seen as the inverse of the last bit
      rx = {rx[70:0], serialOutEn ? serialOut : ~rx[0]};
      #16 spiClk = 1'h0;
    end
    #8 csN = 1'h1;
    serialIn = ~serialIn;
  endtask : xfer
endmodule : sfsr_spi_host

/* File: tb/tb_top.sv */
// Purpose: Self-checking bench of the status register bank
// Assumes: Host model drives every frame
// Notes:   Write cases are table rows, the rest by hand
`timescale 1ns/1ns
`include "sfsr_regs.svh"
module tb_top;
  typedef struct {logic wp; logic [7:0] d; logic lk; logic pr;} sfsr_row_s;
  localparam logic [7:0] opRead = `SFSR_OP_READ_STATUS;
  localparam logic [7:0] opWrsr = `SFSR_OP_WRITE_STATUS;
  localparam logic [7:0] opWrs2 = `SFSR_OP_WRITE_STATUS2;
  localparam logic [7:0] opWren = `SFSR_OP_WRITE_ENABLE;
  localparam logic [7:0] opWrdi = `SFSR_OP_WRITE_DISABLE;
  logic        ref_clk, reset, spiClk, csN, serialIn, serialOut, serialOutEn, wpN;
  logic        engineBusy, engineDone, engineFail, engineAbort, holdAbort, resetOp;
  logic        writeEnabled, arrayProtected, protectionLock, resetCmdEnabled, errorFlag;
  logic [7:0]  statusByteOne, e;
  logic [71:0] rx;
  logic [3:0]  clr [3] = '{4'h4, 4'h2, 4'h1};
  int          mismatches = 0;
  int          tests_run = 0;
  // Cumulative cases: pin, data byte, then expected lock and protection
  sfsr_row_s   rows [8] = '{'{1'h1, 8'h04, 1'h0, 1'h1}, '{1'h1, 8'h80, 1'h1, 1'h0},
    '{1'h1, 8'h84, 1'h1, 1'h1}, '{1'h0, 8'h80, 1'h1, 1'h1}, '{1'h0, 8'h04, 1'h1, 1'h1},
    '{1'h1, 8'h7B, 1'h0, 1'h0}, '{1'h0, 8'h80, 1'h1, 1'h0}, '{1'h0, 8'h84, 1'h1, 1'h0}};

  sfsr_status_reg dut_u (.ref_clk, .reset, .spiClk, .csN, .serialIn, .serialOut,
    .serialOutEn, .wpN, .engineBusy, .engineDone, .engineFail, .engineAbort, .holdAbort,
    .resetOp, .writeEnabled, .arrayProtected, .protectionLock, .resetCmdEnabled,
    .errorFlag, .statusByteOne);
  sfsr_spi_host host_u (.spiClk, .csN, .serialIn, .serialOut, .serialOutEn);

  // Core clock
  initial begin
    ref_clk = 1'h0;
    forever #10 ref_clk = ~ref_clk;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cyc

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : chk

  // Frame, then idle gap long enough for the release to be decoded
  task automatic frm(input logic [15:0] w, input int n);
    host_u.xfer({w, 56'h0}, n, rx);
    cyc(8);
    chk("idle", 2'h0, {serialOutEn, serialOut});
  endtask : frm

  // One-cycle engine pulse: done, abort, hold abort, reset op
  task automatic pulse(input logic [3:0] p);
    {engineDone, engineAbort, holdAbort, resetOp} = p;
    cyc(1);
    {engineDone, engineAbort, holdAbort, resetOp} = 4'h0;
    cyc(1);
  endtask : pulse

  function automatic logic [7:0] b1(input logic lk, er, wp, pr, we, bz);
    return {lk, 1'h0, er, wp, 1'h0, pr, we, bz};
  endfunction : b1

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_of_test

  // Hang guard
  initial begin
    repeat (100000) @(posedge ref_clk);
    mismatches++;
    end_of_test();
  end

  // Main sequence
  initial begin
    reset = 1'h1;
    wpN = 1'h1;
    {engineBusy, engineDone, engineFail, engineAbort, holdAbort, resetOp} = 6'h00;
    cyc(16);
    reset = 1'h0;
    cyc(6);
    foreach (rows[i]) begin
      wpN = rows[i].wp;
      cyc(8);
      frm({opWren, 8'h00}, 8);
      frm({opWrsr, rows[i].d}, 16);
      chk("wel", 1'h0, writeEnabled);
      chk("lock", rows[i].lk, protectionLock);
      chk("prot", rows[i].pr, arrayProtected);
      e = b1(rows[i].lk, 1'h0, rows[i].wp, rows[i].pr, 1'h0, 1'h0);
      frm({opRead, 8'h00}, 40);
      chk("stream", {e, 8'h00, e, 8'h00}, rx[31:0]);
      $display("row %0d done", i);
    end
    // Second reset with latch and lock set
    frm({opWren, 8'h00}, 8);
    wpN = 1'h1;
    reset = 1'h1;
    cyc(3);
    reset = 1'h0;
    cyc(6);
    chk("rst1", 3'h0, {writeEnabled, protectionLock, arrayProtected});
    chk("rst2", 9'h010, {resetCmdEnabled, statusByteOne});
    $display("reset done");
    // Read served while busy, then done with a failed byte
    frm({opWren, 8'h00}, 8);
    engineBusy = 1'h1;
    cyc(4);
    frm({opRead, 8'h00}, 40);
    e = b1(1'h0, 1'h0, 1'h1, 1'h0, 1'h1, 1'h1);
    chk("busy", {e, 8'h01, e, 8'h01}, rx[31:0]);
    engineFail = 1'h1;
    engineBusy = 1'h0;
    pulse(4'h8);
    chk("fail", 2'h2, {errorFlag, writeEnabled});
    // Abort, hold abort and reset op clear the latch but keep the error flag
    foreach (clr[i]) begin
      frm({opWren, 8'h00}, 8);
      pulse(clr[i]);
      chk("clr", 2'h2, {errorFlag, writeEnabled});
    end
    engineFail = 1'h0;
    pulse(4'h8);
    chk("pass", 1'h0, errorFlag);
    $display("engine done");
    // Busy rises mid-stream: first pass old, last pass new
    fork
      frm({opRead, 8'h00}, 72);
      begin
        cyc(20);
        engineBusy = 1'h1;
      end
    join
    engineBusy = 1'h0;
    chk("fresh", 4'h3, {rx[56], rx[48], rx[8], rx[0]});
    $display("fresh done");
    // Partial frames and writes without the latch
    frm({opWren, 8'h00}, 8);
    frm({opWrsr, 8'h84}, 12);
    chk("midbyte", 3'h0, {writeEnabled, protectionLock, arrayProtected});
    frm({opWren, 8'h00}, 8);
    frm(16'hFFFF, 5);
    frm(16'hFF00, 8);
    chk("badop", 1'h1, writeEnabled);
    frm({opWrdi, 8'h00}, 8);
    frm({opWrsr, 8'h04}, 16);
    chk("nowel", 2'h0, {writeEnabled, arrayProtected});
    frm({opRead, 8'h00}, 13);
    $display("abort done");
    // Byte two write sets the reset enable and shows in the stream
    frm({opWren, 8'h00}, 8);
    frm({opWrs2, 8'h10}, 16);
    chk("reset_command_enable", 2'h2, {resetCmdEnabled, writeEnabled});
    frm({opRead, 8'h00}, 40);
    chk("stream2", 32'h10101010, rx[31:0]);
    $display("byte two done");
    end_of_test();
  end
endmodule : tb_top
